/* File: phy_regs_pkg.sv */
// constants and carrier types for the standard status and auto-negotiation registers
package phy_regs_pkg;
  localparam logic [4:0] ADDR_MODE_STATUS = 5'h01;
  localparam logic [4:0] ADDR_ID_HIGH = 5'h02;
  localparam logic [4:0] ADDR_ID_LOW = 5'h03;
  localparam logic [4:0] ADDR_ADVERT = 5'h04;
  localparam logic [4:0] ADDR_PARTNER = 5'h05;
  localparam logic [4:0] ADDR_EXPANSION = 5'h06;
  // mode status fixed capability image: bits 14:11, 8, 6, 3, 0 set
  localparam logic [15:0] STATUS_FIXED = 16'h7949;
  localparam int BIT_JABBER = 1;
  localparam int BIT_LINK = 2;
  localparam int BIT_RFAULT = 4;
  localparam int BIT_AN_DONE = 5;
  // live and latched status bits 5, 4, 2, 1; everything else is fixed
  localparam logic [15:0] STATUS_LIVE = 16'h0036;
  // advertisement writable field and default (selector 00001, abilities 8:5 set)
  localparam logic [15:0] ADV_WMASK = 16'hAFFF;
  localparam logic [15:0] ADV_RESET = 16'h01E1;
  localparam logic [15:0] PARTNER_RESET = 16'h0000;
  localparam int BIT_PDF = 4;
  localparam int BIT_LP_NP = 3;
  localparam int BIT_LOCAL_NP = 2;
  localparam int BIT_PAGE_RX = 1;
  localparam int BIT_LP_AN = 0;
  // identifier: arbitrary neutral values, not any maker's codes
  localparam logic [23:0] OUI_VALUE = 24'h00_1234;
  localparam logic [5:0] MODEL_VALUE = 6'h2A;
  localparam logic [3:0] REV_VALUE = 4'h1;
  // oui bits count from 1: bits 3..18 sit at index 2..17, bits 19..24 at 18..23
  localparam int OUI_HIGH_LSB = 2;
  localparam int OUI_LOW_LSB = 18;
  localparam logic [15:0] READ_ZERO = 16'h0000;

  // management access carrier
  typedef struct packed {
    logic rd;
    logic wr;
    logic [4:0] addr;
    logic [15:0] wdata;
  } mgmt_req_type;

  // events and levels from the negotiation and link logic
  typedef struct packed {
    logic link_up;
    logic remote_fault;
    logic jabber;
    logic an_complete;
    logic an_restart;
    logic pd_fault;
    logic page_rx;
    logic lp_np_able;
    logic lp_an_able;
    logic lp_valid;
    logic [15:0] lp_word;
  } phy_event_type;
endpackage : phy_regs_pkg

/* File: latch_flag.sv */
// one read-clearing latched status bit
`timescale 1ns/10ps
`default_nettype none
module latch_flag
  import phy_regs_pkg::*;
#(
  parameter logic LATCH_LOW = 1'b0
) (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic clr,
  input wire logic cond,
  input wire logic rd_clr,
  output logic flag_q
);
  // cond is the live level of the visible bit; the abnormal level is the
  // inverse of LATCH_LOW and sticks until a read reloads the live level
  always_ff @(posedge ref_clk) begin
    if (sys_rst || clr) begin
      flag_q <= 1'b0;
    end else if (cond == !LATCH_LOW) begin
      flag_q <= !LATCH_LOW; // event beats a same-cycle read clear
    end else if (rd_clr) begin
      flag_q <= cond;
    end
  end
endmodule : latch_flag
`default_nettype wire

/* File: phy_std_status_autoneg_regs.sv */
// management registers 1 to 6: status, identifier, advertisement, partner, expansion
`timescale 1ns/10ps
`default_nettype none
module phy_std_status_autoneg_regs
  import phy_regs_pkg::*;
(
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic soft_rst,
  input wire mgmt_req_type req,
  input wire phy_event_type evt,
  output logic [15:0] rdata_q,
  output logic rvalid_q,
  output logic [15:0] advert_q
);
  logic rd_status;
  logic rd_exp;
  logic clr;
  logic link_q;
  logic rfault_q;
  logic jab_q;
  logic pdf_q;
  logic page_q;
  logic an_done_q;
  logic lp_np_q;
  logic lp_an_q;
  logic [15:0] partner_q;
  logic [15:0] status_w;
  logic [15:0] exp_w;
  logic [15:0] rd_d;
  logic wr_advert;
  logic any_rst;

  // one decoder for every register strobe: access kind and address must both match
  function automatic logic hit(input logic strobe, input logic [4:0] a,
                               input logic [4:0] target);
    return strobe && (a == target);
  endfunction : hit

  // checks run on the one clock; either reset drops every check in flight except soft_reset_a, which only sys_rst drops
  assign any_rst = sys_rst || soft_rst;
  default clocking check_cb @(posedge ref_clk);
  endclocking
  default disable iff (any_rst);

  assign clr = soft_rst;
  assign rd_status = hit(req.rd, req.addr, ADDR_MODE_STATUS);
  assign rd_exp = hit(req.rd, req.addr, ADDR_EXPANSION);
  assign wr_advert = hit(req.wr, req.addr, ADDR_ADVERT);

  // latching status bits share one cell type
  latch_flag #(.LATCH_LOW(1'b1)) link_flag (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .clr(clr),
    .cond(evt.link_up), .rd_clr(rd_status), .flag_q(link_q));
  latch_flag #(.LATCH_LOW(1'b0)) rfault_flag (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .clr(clr),
    .cond(evt.remote_fault), .rd_clr(rd_status), .flag_q(rfault_q));
  latch_flag #(.LATCH_LOW(1'b0)) jabber_flag (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .clr(clr),
    .cond(evt.jabber), .rd_clr(rd_status), .flag_q(jab_q));
  latch_flag #(.LATCH_LOW(1'b0)) pdf_flag (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .clr(clr),
    .cond(evt.pd_fault), .rd_clr(rd_exp), .flag_q(pdf_q));
  latch_flag #(.LATCH_LOW(1'b0)) page_flag (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .clr(clr),
    .cond(evt.page_rx), .rd_clr(rd_exp), .flag_q(page_q));

  // flag cells hold the visible level, so the images read them directly
  logic rfault_v;
  logic jab_v;
  logic pdf_v;
  logic page_v;
  assign rfault_v = rfault_q;
  assign jab_v = jab_q;
  assign pdf_v = pdf_q;
  assign page_v = page_q;

  // negotiation complete: restart wins over completion
  always_ff @(posedge ref_clk) begin
    if (sys_rst || clr || evt.an_restart) begin
      an_done_q <= 1'b0;
    end else if (evt.an_complete) begin
      an_done_q <= 1'b1;
    end
  end

  // partner ability word captured when a base page is valid
  always_ff @(posedge ref_clk) begin
    if (sys_rst || clr || evt.an_restart) begin
      partner_q <= PARTNER_RESET;
    end else if (evt.lp_valid) begin
      partner_q <= evt.lp_word;
    end
  end

  // partner capability levels for the expansion word
  always_ff @(posedge ref_clk) begin
    if (sys_rst || clr) begin
      lp_np_q <= 1'b0;
      lp_an_q <= 1'b0;
    end else begin
      lp_np_q <= evt.lp_np_able;
      lp_an_q <= evt.lp_an_able;
    end
  end

  // advertisement: only writable bits take write data
  always_ff @(posedge ref_clk) begin
    if (sys_rst || clr) begin
      advert_q <= ADV_RESET;
    end else if (wr_advert) begin
      advert_q <= req.wdata & ADV_WMASK;
    end
  end

  // status image: constants plus live and latched bits
  always_comb begin
    status_w = STATUS_FIXED;
    status_w[BIT_LINK] = link_q;
    status_w[BIT_RFAULT] = rfault_v;
    status_w[BIT_JABBER] = jab_v;
    status_w[BIT_AN_DONE] = an_done_q;
  end

  // expansion image: reserved bits read zero
  always_comb begin
    exp_w = READ_ZERO;
    exp_w[BIT_PDF] = pdf_v;
    exp_w[BIT_LP_NP] = lp_np_q;
    exp_w[BIT_LOCAL_NP] = 1'b1;
    exp_w[BIT_PAGE_RX] = page_v;
    exp_w[BIT_LP_AN] = lp_an_q;
  end

  // read mux; unmapped addresses read zero
  always_comb begin
    unique case (req.addr)
      ADDR_MODE_STATUS: rd_d = status_w;
      ADDR_ID_HIGH: rd_d = OUI_VALUE[OUI_HIGH_LSB +: 16];
      ADDR_ID_LOW: rd_d = {OUI_VALUE[OUI_LOW_LSB +: 6], MODEL_VALUE, REV_VALUE};
      ADDR_ADVERT: rd_d = advert_q;
      ADDR_PARTNER: rd_d = partner_q;
      ADDR_EXPANSION: rd_d = exp_w;
      default: rd_d = READ_ZERO;
    endcase
  end

  // read data registered one cycle after the request
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      rdata_q <= READ_ZERO;
      rvalid_q <= 1'b0;
    end else begin
      rvalid_q <= req.rd;
      if (req.rd) begin
        rdata_q <= rd_d;
      end
    end
  end

  // steps of a register read and of a link drop
  sequence read_taken_s;
    req.rd;
  endsequence
  sequence link_drop_s;
    !evt.link_up;
  endsequence
  sequence link_back_unread_s;
    evt.link_up && !rd_status;
  endsequence

  // link bit stays low after a drop until a status read
  link_latch_a: assert property (link_drop_s |=> !link_q)
    else $error("link bit missed drop");
  link_hold_a: assert property (link_drop_s ##1 link_back_unread_s |=> !link_q)
    else $error("link bit rose without a read");
  link_reload_a: assert property (rd_status && evt.link_up |=> link_q)
    else $error("link bit not reloaded");
  rfault_set_a: assert property (evt.remote_fault |=> rfault_v)
    else $error("remote fault not latched");
  rfault_hold_a: assert property (rfault_v && !rd_status |=> rfault_v)
    else $error("remote fault lost");
  jabber_set_a: assert property (evt.jabber |=> jab_v)
    else $error("jabber not latched");
  read_redo_a: assert property (rd_status && !evt.jabber |=> !jab_v)
    else $error("jabber not re-evaluated");
  status_const_a: assert property ((status_w & ~STATUS_LIVE) == STATUS_FIXED)
    else $error("status constants wrong");
  // write data lands masked; reserved bits never show
  advert_write_a: assert property (wr_advert |=> advert_q == ($past(req.wdata) & ADV_WMASK))
    else $error("advert write lost");
  advert_reserved_a: assert property ((advert_q & ~ADV_WMASK) == READ_ZERO)
    else $error("reserved advert bits set");
  // software reset must not be masked by its own disable
  soft_reset_a: assert property (disable iff (sys_rst)
    soft_rst |=> advert_q == ADV_RESET && partner_q == PARTNER_RESET && !link_q && !jab_v)
    else $error("soft reset missed");
  an_restart_a: assert property (evt.an_restart |=> !an_done_q)
    else $error("complete not cleared");
  an_done_a: assert property (evt.an_complete && !evt.an_restart |=> an_done_q)
    else $error("complete not set");
  partner_hold_a: assert property (
    !evt.lp_valid && !evt.an_restart |=> $stable(partner_q))
    else $error("partner word drifted");
  partner_take_a: assert property (
    evt.lp_valid && !evt.an_restart |=> partner_q == $past(evt.lp_word))
    else $error("partner word missed");
  page_set_a: assert property (evt.page_rx |=> page_v)
    else $error("page flag not set");
  page_redo_a: assert property (rd_exp && !evt.page_rx |=> !page_v)
    else $error("page flag not re-evaluated");
  pdf_set_a: assert property (evt.pd_fault |=> pdf_v)
    else $error("pd fault not set");
  partner_level_a: assert property (
    1'b1 |=> lp_np_q == $past(evt.lp_np_able) && lp_an_q == $past(evt.lp_an_able))
    else $error("partner levels not copied");
  local_np_a: assert property (exp_w[BIT_LOCAL_NP] && exp_w[15:5] == 11'h000)
    else $error("expansion image wrong");
  // every read answers exactly one cycle later, and only a read does
  read_answer_a: assert property (read_taken_s |=> rvalid_q)
    else $error("read not answered");
  read_idle_a: assert property (!req.rd |=> !rvalid_q)
    else $error("answer without a read");
endmodule : phy_std_status_autoneg_regs
`default_nettype wire

/* File: mgmt_station.sv */
// station management model issuing single register reads and writes
`timescale 1ns/10ps
`default_nettype none
module mgmt_station
  import phy_regs_pkg::*;
(
  input wire logic ref_clk,
  input wire logic [15:0] rdata_q,
  input wire logic rvalid_q,
  output var mgmt_req_type req
);
  initial req = '0;
  // one-cycle request; released fields are inverted so stale values never pass
  task automatic access(input logic wr, input logic [4:0] a, input logic [15:0] d,
                        output logic [15:0] q);
    int n;
    @(negedge ref_clk);
    req = '{rd: !wr, wr: wr, addr: a, wdata: d};
    @(negedge ref_clk);
    req = '{rd: 1'b0, wr: 1'b0, addr: ~a, wdata: ~d};
    n = 0;
    while (!wr && rvalid_q !== 1'b1 && n < 3) begin
      @(negedge ref_clk);
      n++;
    end
    q = (rvalid_q === 1'b1) ? rdata_q : 16'hxxxx;
  endtask : access
endmodule : mgmt_station
`default_nettype wire

/* File: phy_std_status_autoneg_regs_test.sv */
// self-checking bench for the status and auto-negotiation registers
`timescale 1ns/10ps
`default_nettype none
module phy_std_status_autoneg_regs_test;
  import phy_regs_pkg::*;
  logic ref_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic soft_rst = 1'b0;
  phy_event_type evt = '0;
  phy_event_type lvl = '0;
  mgmt_req_type req;
  logic [15:0] rdata_q;
  logic [15:0] advert_q;
  logic [15:0] q;
  logic rvalid_q;
  int num_errors = 0;
  int n_tests = 0;
  // free-running 100 MHz clock
  always #5 ref_clk = ~ref_clk;
  phy_std_status_autoneg_regs dut (.ref_clk(ref_clk), .sys_rst(sys_rst),
    .soft_rst(soft_rst), .req(req), .evt(evt), .rdata_q(rdata_q),
    .rvalid_q(rvalid_q), .advert_q(advert_q));
  mgmt_station station (.ref_clk(ref_clk), .rdata_q(rdata_q), .rvalid_q(rvalid_q),
    .req(req));
  // galois lfsr for write data and partner words
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {1'b0, s[15:1]} ^ (s[0] ? 16'hB400 : 16'h0000);
  endfunction : lfsr
  // expected status word from link, remote fault, complete and jabber
  function automatic logic [15:0] st(input logic lk, rf, an, jb);
    return STATUS_FIXED | {10'h000, an, rf, 1'b0, lk, jb, 1'b0};
  endfunction : st
  function automatic logic [15:0] ex(input logic pd, np, pg, an);
    return {11'h000, pd, np, 1'b1, pg, an};
  endfunction : ex
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic rd(input logic [4:0] a, input logic [15:0] exp);
    station.access(1'b0, a, 16'h0000, q);
    chk(q, exp);
  endtask : rd
  // events held one cycle over the live levels
  task automatic pulse(input phy_event_type e);
    @(negedge ref_clk);
    evt = lvl | e;
    @(negedge ref_clk);
    evt = lvl;
    evt.lp_word = ~e.lp_word;
  endtask : pulse
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : print_verdict
  // main sequence
  initial begin
    phy_event_type e;
    logic [15:0] s;
    logic [15:0] d;
    s = 16'h80AD;
    repeat (3) @(negedge ref_clk);
    sys_rst = 1'b0;
    rd(ADDR_ID_HIGH, OUI_VALUE[17:2]);
    rd(ADDR_ID_LOW, {OUI_VALUE[23:18], MODEL_VALUE, REV_VALUE});
    rd(5'h07, READ_ZERO);
    rd(ADDR_EXPANSION, ex(0, 0, 0, 0));
    $display("test identity done");
    lvl.link_up = 1'b1;
    pulse('0);
    rd(ADDR_MODE_STATUS, st(0, 0, 0, 0));
    rd(ADDR_MODE_STATUS, st(1, 0, 0, 0));
    lvl.link_up = 1'b0;
    pulse('0);
    lvl.link_up = 1'b1;
    e = '0;
    e.remote_fault = 1'b1;
    e.jabber = 1'b1;
    e.an_complete = 1'b1;
    pulse(e);
    rd(ADDR_MODE_STATUS, st(0, 1, 1, 1));
    rd(ADDR_MODE_STATUS, st(1, 0, 1, 0));
    e = '0;
    e.an_restart = 1'b1;
    pulse(e);
    rd(ADDR_MODE_STATUS, st(1, 0, 0, 0));
    $display("test status done");
    rd(ADDR_ADVERT, ADV_RESET);
    for (int i = 0; i < 5; i++) begin
      s = lfsr(s);
      d = (i == 0) ? 16'hFFFF : s;
      station.access(1'b1, ADDR_ADVERT, d, q);
      rd(ADDR_ADVERT, d & ADV_WMASK);
      chk(advert_q, d & ADV_WMASK);
    end
    station.access(1'b1, ADDR_MODE_STATUS, 16'h0000, q);
    rd(ADDR_MODE_STATUS, st(1, 0, 0, 0));
    e = '0;
    e.lp_valid = 1'b1;
    e.lp_word = lfsr(s);
    pulse(e);
    rd(ADDR_PARTNER, e.lp_word);
    $display("test advertisement done");
    @(negedge ref_clk);
    soft_rst = 1'b1;
    @(negedge ref_clk);
    soft_rst = 1'b0;
    rd(ADDR_ADVERT, ADV_RESET);
    rd(ADDR_PARTNER, PARTNER_RESET);
    $display("test soft reset done");
    lvl.lp_np_able = 1'b1;
    lvl.lp_an_able = 1'b1;
    e = '0;
    e.pd_fault = 1'b1;
    e.page_rx = 1'b1;
    pulse(e);
    rd(ADDR_EXPANSION, ex(1, 1, 1, 1));
    rd(ADDR_EXPANSION, ex(0, 1, 0, 1));
    $display("test expansion done");
    print_verdict();
  end
  // watchdog well beyond the fewer than one hundred cycles the tests need
  initial begin
    #100000;
    num_errors++;
    print_verdict();
  end
endmodule : phy_std_status_autoneg_regs_test
`default_nettype wire
